// *** hw/adc_host_pkg.sv ***
package adc_host_pkg;

	// Clock rate of the host logic
	localparam int SYS_CLK_HZ = 200_000_000;

	// Power-up waits
	localparam int INIT_INTREF_MS = 20;
	localparam int INIT_EXTREF_US = 10;
	localparam int INIT_INTREF_CYC = INIT_INTREF_MS * (SYS_CLK_HZ / 1_000);
	localparam int INIT_EXTREF_CYC = INIT_EXTREF_US * (SYS_CLK_HZ / 1_000_000);

	// Serial clock limits
	localparam int SCLK_MAX_KHZ = 2_100;
	localparam int SCLK_QMAX_KHZ = 2_097;
	// Half period rounded up so the rate stays at or below the limit
	localparam int SCLK_HALF_CYC = (SYS_CLK_HZ / 1_000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);

	// Worst-case conversion time, used when not watching the end edge
	localparam int CONV_MAX_NS = 7_500;
	localparam int CONV_MAX_CYC = CONV_MAX_NS / 5;

	// Least chip-select-high time and acquisition time
	localparam int CS_HIGH_NS = 500;
	localparam int CS_HIGH_CYC = (CS_HIGH_NS + 4) / 5;
	localparam int ACQ_NS = 1_500;
	localparam int ACQ_CYC = (ACQ_NS + 4) / 5;

	// Readout framing
	localparam int RESULT_BITS = 12;
	localparam int MIN_FALL_EDGES = 13;
	localparam int BYTE_EDGES = 16;

	// Pins toward the converter
	typedef struct packed {
		logic chip_select_low;
		logic sclk;
	} pins_out_s;

	// Result handed to the user
	typedef struct packed {
		logic [11:0] data;
		logic framing_ok;
	} result_s;

endpackage : adc_host_pkg

// *** hw/adc_sclk_div.sv ***
`timescale 1ns/1ps
// Serial clock divider: one-cycle tick at every half period while running
module adc_sclk_div #(
	parameter int HALF_CYC = 48
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_run,
	output logic o_tick
);
	logic [15:0] cnt_reg;
	wire logic last = (cnt_reg == 16'(HALF_CYC - 1));

	// Counter restarts whenever clocking is stopped
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run || last) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	assign o_tick = i_run && last;
endmodule : adc_sclk_div

// *** hw/adc_host.sv ***
`timescale 1ns/1ps
module adc_host #(
	parameter int INIT_INT_CYC = adc_host_pkg::INIT_INTREF_CYC,
	parameter int INIT_EXT_CYC = adc_host_pkg::INIT_EXTREF_CYC
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic i_int_ref,
	input wire logic i_wait_eoc,
	input wire logic i_two_bytes,
	input wire logic i_dout,
	output logic o_chip_select_low,
	output logic o_sclk,
	output logic o_ready,
	output logic o_busy,
	output logic o_valid,
	output logic [11:0] o_data,
	output logic o_frame_ok
);
	typedef enum {ST_INIT, ST_IDLE, ST_CONV, ST_SHIFT, ST_GAP} state_e;

	state_e state_reg, state_next;
	logic [23:0] cnt_reg, cnt_next;
	logic [4:0] fall_reg, fall_next;
	logic [15:0] shift_reg, shift_next;
	adc_host_pkg::pins_out_s pins_reg, pins_next;
	adc_host_pkg::result_s res_reg, res_next;
	logic valid_reg, valid_next;
	logic din_meta_reg, din_sync_reg, din_prev_reg;
	logic tick;

	// Bit count to clock: two full bytes or the 13 edges minimum
	wire logic [4:0] edges_needed = i_two_bytes ? 5'(adc_host_pkg::BYTE_EDGES)
		: 5'(adc_host_pkg::MIN_FALL_EDGES);
	wire logic [23:0] init_cyc = i_int_ref ? 24'(INIT_INT_CYC) : 24'(INIT_EXT_CYC);
	wire logic dout_rise = din_sync_reg && !din_prev_reg;
	wire logic run_clk = (state_reg == ST_SHIFT);

	// Data pin comes from the converter, so synchronise it
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			din_meta_reg <= 1'b0;
			din_sync_reg <= 1'b0;
			din_prev_reg <= 1'b0;
		end else begin
			din_meta_reg <= i_dout;
			din_sync_reg <= din_meta_reg;
			din_prev_reg <= din_sync_reg;
		end
	end

	adc_sclk_div #(
		.HALF_CYC(adc_host_pkg::SCLK_HALF_CYC)
	) u_div (
		.i_clk(I_CLK_SYS),
		.i_rst(I_RST),
		.i_run(run_clk),
		.o_tick(tick)
	);

	// Sequencer: init wait, conversion, readout, chip-select-high gap
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		fall_next = fall_reg;
		shift_next = shift_reg;
		pins_next = pins_reg;
		res_next = res_reg;
		valid_next = 1'b0;
		case (state_reg)
			ST_INIT: begin
				// Start requests ignored until the wait ends
				if (cnt_reg >= init_cyc - 24'h00_0001) begin
					state_next = ST_IDLE;
					cnt_next = 24'h00_0000;
				end else begin
					cnt_next = cnt_reg + 24'h00_0001;
				end
			end
			ST_IDLE: begin
				if (i_start) begin
					pins_next.sclk = 1'b0;
					pins_next.chip_select_low = 1'b1;
					cnt_next = 24'h00_0000;
					state_next = ST_CONV;
				end
			end
			ST_CONV: begin
				// Clock held low throughout; leave on abort, end edge or time-out
				cnt_next = cnt_reg + 24'h00_0001;
				if (i_abort) begin
					pins_next.chip_select_low = 1'b0;
					cnt_next = 24'(adc_host_pkg::ACQ_CYC);
					state_next = ST_GAP;
				end else if ((i_wait_eoc && dout_rise)
					|| cnt_reg >= 24'(adc_host_pkg::CONV_MAX_CYC)) begin
					fall_next = 5'h00;
					shift_next = 16'h0000;
					state_next = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (tick) begin
					pins_next.sclk = !pins_reg.sclk;
					if (!pins_reg.sclk) begin
						// Rising edge: capture the bit the device set up
						shift_next = {shift_reg[14:0], din_sync_reg};
					end else begin
						fall_next = fall_reg + 5'h01;
						if (fall_reg + 5'h01 == edges_needed) begin
							state_next = ST_GAP;
						end
					end
				end
			end
			ST_GAP: begin
				// Release chip select once the last falling edge is out
				if (pins_reg.chip_select_low) begin
					pins_next.chip_select_low = 1'b0;
					cnt_next = 24'(adc_host_pkg::CS_HIGH_CYC);
					if (fall_reg == edges_needed) begin
						// Capture holds leading one, result, then pad in two-byte mode
						if (i_two_bytes) begin
							res_next.framing_ok = shift_reg[15]
								&& (shift_reg[2:0] == 3'h0);
							res_next.data = shift_reg[14:3];
						end else begin
							res_next.framing_ok = shift_reg[12];
							res_next.data = shift_reg[11:0];
						end
						valid_next = 1'b1;
					end
				end else if (cnt_reg <= 24'h00_0001) begin
					cnt_next = 24'h00_0000;
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg - 24'h00_0001;
				end
			end
			default: begin
				state_next = ST_INIT;
			end
		endcase
	end

	// State registers
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			state_reg <= ST_INIT;
			cnt_reg <= 24'h00_0000;
			fall_reg <= 5'h00;
			shift_reg <= 16'h0000;
			pins_reg <= '0;
			res_reg <= '0;
			valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			fall_reg <= fall_next;
			shift_reg <= shift_next;
			pins_reg <= pins_next;
			res_reg <= res_next;
			valid_reg <= valid_next;
		end
	end

	// Chip select is active low at the pin
	assign o_chip_select_low = !pins_reg.chip_select_low;
	assign o_sclk = pins_reg.sclk;
	assign o_ready = (state_reg == ST_IDLE);
	assign o_busy = !o_ready;
	assign o_valid = valid_reg;
	assign o_data = res_reg.data;
	assign o_frame_ok = res_reg.framing_ok;
endmodule : adc_host

// *** sim/adc_host_assertions.sv ***
`timescale 1ns/1ps
// Host pin timing
module adc_host_assertions (
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	input wire logic i_start,
	input wire logic o_chip_select_low,
	input wire logic o_sclk,
	input wire logic o_ready,
	input wire logic o_valid
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	sequence s_take;
		o_ready && i_start;
	endsequence
	a_take_start: assert property (s_take |=> !o_chip_select_low && !o_ready)
		else $error("start not taken");
	a_init_hold: assert property ($fell(I_RST) |-> o_chip_select_low [*8])
		else $error("select during init");
	a_gate_closed: assert property (!o_ready && o_chip_select_low |=> o_chip_select_low)
		else $error("early select");
	a_idle_low: assert property (o_chip_select_low |-> !o_sclk)
		else $error("clock not idle low");
	a_conv_quiet: assert property ($fell(o_chip_select_low) |-> !o_sclk ##1 !o_sclk [*8])
		else $error("clock in conversion");
	a_half_period: assert property ($changed(o_sclk) |=> $stable(o_sclk) [*8])
		else $error("clock too fast");
	a_gap_hold: assert property ($rose(o_chip_select_low) |-> (o_chip_select_low && !o_ready) [*8])
		else $error("gap too short");
	a_valid_end: assert property (o_valid |-> o_chip_select_low && !o_sclk)
		else $error("result before deselect");
endmodule : adc_host_assertions
bind adc_host adc_host_assertions chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_start(i_start),
	.o_chip_select_low(o_chip_select_low), .o_sclk(o_sclk), .o_ready(o_ready), .o_valid(o_valid));

// *** sim/adc_dev_model.sv ***
`timescale 1ns/1ps
// Converter model, 1 us conversion
module adc_dev_model (
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic [11:0] i_result,
	output logic o_dout
);
	logic v = 1'b0;
	logic [11:0] sh = 12'h000;
	// Released pin shows inverse of last level, so no stale value
	assign o_dout = i_cs_n ? ~v : v;
	// Low while busy, high at end
	always @(negedge i_cs_n) begin
		v = 1'b0;
		sh = i_result;
		#1000;
		if (!i_cs_n)
			v = 1'b1;
	end
	// MSB first, then zeros
	always @(negedge i_sclk) begin
		if (!i_cs_n) begin
			v = sh[11];
			sh = sh << 1;
		end
	end
endmodule : adc_dev_model

// *** sim/adc_host_test.sv ***
`timescale 1ns/1ps
module adc_host_test;
	logic I_CLK_SYS = 0;
	logic I_RST = 1;
	logic start = 0, abort = 0, int_ref = 0, weoc = 1, two = 0;
	logic dout, cs_n, sclk, ready, busy, valid, fok;
	logic [11:0] data, res = 0;
	int errors = 0, n_compared = 0, k;
	// System clock
	always #2.5 I_CLK_SYS = ~I_CLK_SYS;
	adc_host #(.INIT_INT_CYC(20), .INIT_EXT_CYC(10)) uut (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
		.i_start(start), .i_abort(abort), .i_int_ref(int_ref), .i_wait_eoc(weoc),
		.i_two_bytes(two), .i_dout(dout), .o_chip_select_low(cs_n), .o_sclk(sclk),
		.o_ready(ready), .o_busy(busy), .o_valid(valid), .o_data(data), .o_frame_ok(fok));
	adc_dev_model dev (.i_cs_n(cs_n), .i_sclk(sclk), .i_result(res), .o_dout(dout));
	task check(input logic [12:0] seen, input logic [12:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	// Expected capture: leading one ahead of the result
	function automatic logic [12:0] expect_word(input logic [11:0] val);
		return {1'b1, val};
	endfunction : expect_word
	task conclude;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	// Bounded wait on ready or valid; k holds cycles spent
	task wait_for(input int w);
		for (k = 0; k < 9000 && (w ? valid : ready) !== 1'b1; k++)
			@(negedge I_CLK_SYS);
		if (k == 9000) begin
			errors++;
			conclude();
		end
	endtask : wait_for
	task go;
		wait_for(0);
		start = 1;
		@(negedge I_CLK_SYS);
		start = 0;
	endtask : go
	task frame(input logic w, input logic t, input logic [11:0] val);
		res = val;
		weoc = w;
		two = t;
		go();
		check(13'(busy), 13'h1);
		wait_for(1);
		check({fok, data}, expect_word(val));
		wait_for(0);
		check(13'(busy), 13'h0);
		check(13'(k >= adc_host_pkg::CS_HIGH_CYC - 2), 13'h1);
		$display("frame %h done", val);
	endtask : frame
	initial begin
		void'($urandom(88125));
		repeat (6) @(negedge I_CLK_SYS);
		I_RST = 0;
		repeat (5) @(negedge I_CLK_SYS);
		check(13'(ready), 13'h0);
		frame(1, 1, 12'h000);
		frame(0, 0, 12'hFFF);
		for (int i = 0; i < 8; i++)
			frame(i[0], i[1], 12'($urandom));
		// Abort mid-conversion, then a clean frame
		go();
		// Random abort point, well inside the 1 us conversion
		repeat (10 + $urandom % 100) @(negedge I_CLK_SYS);
		abort = 1;
		@(negedge I_CLK_SYS);
		abort = 0;
		wait_for(0);
		check(13'(k >= adc_host_pkg::ACQ_CYC - 2), 13'h1);
		$display("abort done");
		frame(1, 0, 12'hA5C);
		// Second reset with the longer wait
		I_RST = 1;
		int_ref = 1;
		repeat (2) @(negedge I_CLK_SYS);
		I_RST = 0;
		repeat (15) @(negedge I_CLK_SYS);
		check(13'(ready), 13'h0);
		frame(1, 0, 12'h801);
		conclude();
	end
endmodule : adc_host_test
